// >>> rtl/rtcc_pkg.sv
package rtcc_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_FLAGS    = 8'h00;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h01;
	localparam logic [7:0] OFS_CFG1     = 8'h03;
	localparam logic [7:0] OFS_TMR_CFG  = 8'h05;
	localparam logic [7:0] OFS_TMR_CNT  = 8'h16;
	localparam logic [7:0] OFS_TMR_INIT = 8'h17;
	localparam logic [7:0] OFS_TEMP_HI  = 8'h1A;
	localparam logic [7:0] OFS_TEMP_LO  = 8'h1B;
	localparam logic [7:0] OFS_TS_CFG   = 8'h1C;

	// ==========================================================
	// Field positions, masks and reset values
	localparam int BIT_TIF    = 2;
	localparam int BIT_TSF    = 3;
	localparam int BIT_RET    = 4;
	localparam int BIT_RUN    = 4;
	localparam int BIT_HOLD   = 3;
	localparam int BIT_RELOAD = 2;
	localparam int BIT_AUTO   = 7;
	localparam int BIT_SINGLE = 6;
	localparam int IVL_LSB    = 3;
	localparam logic [7:0] FLAG_MASK    = 8'h0C;
	localparam logic [7:0] IRQ_EN_MASK  = 8'h7F;
	localparam logic [7:0] CFG1_MASK    = 8'h1F;
	localparam logic [7:0] TMR_CFG_MASK = 8'h1F;
	localparam logic [7:0] TS_CFG_MASK  = 8'hB8;
	localparam logic [7:0] REG_RST      = 8'h00;
	localparam logic [15:0] COMP_NOMINAL = 16'h8000;

	// ==========================================================
	// Serial slave constants
	localparam logic [7:0] DEV_WR_BYTE = 8'hD0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ==========================================================
	// Timing
	localparam int unsigned CORE_HZ      = 100_000_000;
	localparam int unsigned CONV_TIME_MS = 70;
	localparam int unsigned CONV_CYCLES_DFLT = CORE_HZ / 1000 * CONV_TIME_MS;
	localparam int unsigned BASE_TICK_HZ = 4096;
	localparam int unsigned BASE_TICK_CYCLES_DFLT = CORE_HZ / BASE_TICK_HZ;
	localparam logic [31:0] RATE_DIV0 = 32'h0000_0001;
	localparam logic [31:0] RATE_DIV1 = 32'h0000_0040;
	localparam logic [31:0] RATE_DIV2 = 32'h0000_1000;
	localparam logic [31:0] RATE_DIV3 = 32'h0003_C000;
	localparam logic [31:0] IVL_BASE_TICKS = 32'h0000_1000;

	// ==========================================================
	// State encodings
	typedef enum logic [8:0] {
		LS_IDLE     = 9'h001,
		LS_ADDR     = 9'h002,
		LS_ADDR_ACK = 9'h004,
		LS_REG      = 9'h008,
		LS_REG_ACK  = 9'h010,
		LS_WDATA    = 9'h020,
		LS_WDAT_ACK = 9'h040,
		LS_RDATA    = 9'h080,
		LS_RACK     = 9'h100
	} rtcc_link_state_t;

	typedef enum logic [2:0] {
		TS_IDLE  = 3'h1,
		TS_COUNT = 3'h2,
		TS_DONE  = 3'h4
	} rtcc_tmr_state_t;

endpackage : rtcc_pkg

// >>> rtl/rtcc_core.sv
// Functional notes
// RL1 - Auto conversion bit set: convert periodically at the interval field's rate.
// RL2 - Auto bit clear: writing one-shot bit launches exactly one conversion.
// RL3 - One-shot bit clears itself when its 70 ms conversion completes.
// RL4 - Each conversion updates trim divider ratio and both temperature registers.
// RL5 - Interrupt event sets its status flag and pulls interrupt pin low; code pulls the pin low only for flags enabled in irq_en_reg.
// RL6 - Reading status register clears flags and releases the interrupt pin.
// RL7 - Retention bit stops all functions but the serial port; contents kept.
// RL8 - Clearing retention bit resumes counting from retained values.
// RL9 - In retention the main external supply is forced active.
// RL10 - Run 1, hold 0 from reset state loads initial value, counts down.
// RL11 - Two-bit rate field selects the countdown rate.
// RL12 - Autoreload set: at zero reload initial value and restart.
// RL13 - At zero set timer flag; pin asserts only if timer irq enabled.
// RL14 - Run 0, hold 0 keeps timer reset; initial value writable.
// RL15 - Run 1, hold 1 freezes count; clearing hold resumes from it.
// RL16 - Software sets hold only with run set; never run 0, hold 1.
// RL17 - Slave answers only D0h for write and D1h for read.
// RL18 - Mismatched address byte: ignore bus until next START.
// RL19 - Byte after write address byte is the register address.
// RL20 - Sample SDA on SCL rise; change SDA after SCL fall.
// RL21 - MSB first; receiver drives ninth bit low; device acks all writes.
// RL22 - Master acks wanted reads, nacks last; device then releases SDA.
// RL23 - Read without register address starts at current address counter.
// RL24 - Address-only write then repeated START read begins at chosen location.
// RL25 - Address counter advances after each data byte written or read.
module rtcc_core
	import rtcc_pkg::*;
#(
	parameter int unsigned CONV_CYCLES      = CONV_CYCLES_DFLT,
	parameter int unsigned BASE_TICK_CYCLES = BASE_TICK_CYCLES_DFLT
)
(
	// Clocks and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        link_clk,
	// Two-wire serial pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Temperature sensor result
	input  wire logic [15:0] temp_sample,
	// Time base and supply control
	output logic [15:0]      frac_div_ratio,
	output logic             osc_enable,
	output logic             supply_main_force,
	output logic             conv_active,
	// Interrupt pin
	output logic             int_n
);

	// ==========================================================
	// Link domain: pin synchronisers
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;

	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
		end
		else
		begin
			{scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
		end
	end

	wire scl_rise  = scl_s & ~scl_d;
	wire scl_fall  = ~scl_s & scl_d;
	wire start_det = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;

	// ==========================================================
	// Link domain: serial slave
	rtcc_link_state_t lst_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] rx_reg, tx_reg, ptr_reg, fetch_reg;
	logic [7:0] wr_addr_reg, wr_data_reg, rd_addr_reg;
	logic       wr_tgl_reg, rd_tgl_reg, rw_reg, mack_reg, oe_reg;
	wire        byte_done = scl_fall && (bit_cnt_reg == BITS_PER_BYTE);

	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lst_reg     <= LS_IDLE;
			bit_cnt_reg <= 4'h0;
			rx_reg      <= 8'h00;
			tx_reg      <= 8'h00;
			ptr_reg     <= 8'h00;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
			rd_addr_reg <= 8'h00;
			wr_tgl_reg  <= 1'b0;
			rd_tgl_reg  <= 1'b0;
			rw_reg      <= 1'b0;
			mack_reg    <= 1'b0;
			oe_reg      <= 1'b0;
		end
		else if (start_det)
		begin
			lst_reg     <= LS_ADDR; // RL18
			bit_cnt_reg <= 4'h0;
			oe_reg      <= 1'b0;
		end
		else if (stop_det)
		begin
			lst_reg <= LS_IDLE;
			oe_reg  <= 1'b0;
		end
		else
		begin
			unique case (lst_reg)
				LS_IDLE:
				begin
				end
				LS_ADDR, LS_REG, LS_WDATA:
				begin
					if (scl_rise)
					begin
						rx_reg      <= {rx_reg[6:0], sda_s}; // RL20 RL21
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					else if (byte_done)
					begin
						bit_cnt_reg <= 4'h0;
						oe_reg      <= 1'b1; // RL21
						if (lst_reg == LS_ADDR)
						begin
							rw_reg <= rx_reg[0];
							if (rx_reg[7:1] == DEV_WR_BYTE[7:1]) // RL17
								lst_reg <= LS_ADDR_ACK;
							else
							begin
								lst_reg <= LS_IDLE; // RL18
								oe_reg  <= 1'b0;
							end
						end
						else if (lst_reg == LS_REG)
						begin
							ptr_reg <= rx_reg; // RL19 RL24
							lst_reg <= LS_REG_ACK;
						end
						else
						begin
							wr_addr_reg <= ptr_reg;
							wr_data_reg <= rx_reg;
							wr_tgl_reg  <= ~wr_tgl_reg;
							ptr_reg     <= ptr_reg + 8'h01; // RL25
							lst_reg     <= LS_WDAT_ACK;
						end
					end
				end
				LS_ADDR_ACK:
				begin
					if (scl_rise && rw_reg)
					begin
						rd_addr_reg <= ptr_reg; // RL23
						rd_tgl_reg  <= ~rd_tgl_reg;
						ptr_reg     <= ptr_reg + 8'h01; // RL25
					end
					else if (scl_fall)
					begin
						bit_cnt_reg <= 4'h0;
						if (rw_reg)
						begin
							lst_reg <= LS_RDATA;
							tx_reg  <= fetch_reg;
							oe_reg  <= ~fetch_reg[7]; // RL20
						end
						else
						begin
							lst_reg <= LS_REG;
							oe_reg  <= 1'b0;
						end
					end
				end
				LS_REG_ACK, LS_WDAT_ACK:
				begin
					if (scl_fall)
					begin
						lst_reg     <= LS_WDATA;
						bit_cnt_reg <= 4'h0;
						oe_reg      <= 1'b0;
					end
				end
				LS_RDATA:
				begin
					if (scl_rise)
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					else if (byte_done)
					begin
						lst_reg <= LS_RACK;
						oe_reg  <= 1'b0; // RL22
					end
					else if (scl_fall)
					begin
						tx_reg <= {tx_reg[6:0], 1'b0}; // RL21
						oe_reg <= ~tx_reg[6]; // RL20
					end
				end
				LS_RACK:
				begin
					if (scl_rise)
					begin
						mack_reg <= ~sda_s;
						if (!sda_s)
						begin
							rd_addr_reg <= ptr_reg;
							rd_tgl_reg  <= ~rd_tgl_reg;
							ptr_reg     <= ptr_reg + 8'h01; // RL25
						end
					end
					else if (scl_fall)
					begin
						bit_cnt_reg <= 4'h0;
						if (mack_reg)
						begin
							lst_reg <= LS_RDATA;
							tx_reg  <= fetch_reg;
							oe_reg  <= ~fetch_reg[7];
						end
						else
							lst_reg <= LS_IDLE; // RL22
					end
				end
			endcase
		end
	end

	assign sda_oe  = oe_reg;
	assign sda_out = 1'b0;

	a_addr_match: assert property (@(posedge link_clk) disable iff (!reset_n) // RL17
		$rose(lst_reg == LS_ADDR_ACK) |-> $past(rx_reg[7:1]) == DEV_WR_BYTE[7:1])
		else $error("Address acknowledged without a match.");

	a_ack_drive: assert property (@(posedge link_clk) disable iff (!reset_n) // RL21
		(lst_reg == LS_REG_ACK || lst_reg == LS_WDAT_ACK) |-> oe_reg)
		else $error("Write byte left unacknowledged.");

	// ==========================================================
	// Link domain: read data return from the core side
	logic ack_m, ack_s, ack_d;
	logic rd_ack_tgl_reg;
	logic [7:0] rd_data_reg;

	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{ack_m, ack_s, ack_d} <= 3'h0;
			fetch_reg <= 8'h00;
		end
		else
		begin
			{ack_m, ack_s, ack_d} <= {rd_ack_tgl_reg, ack_m, ack_s};
			// The data word is stable long before the toggle arrives here.
			if (ack_s ^ ack_d)
				fetch_reg <= rd_data_reg;
		end
	end

	// ==========================================================
	// Core domain: request toggle synchronisers
	logic wr_m, wr_s, wr_d, rd_m, rd_s, rd_d;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{wr_m, wr_s, wr_d} <= 3'h0;
			{rd_m, rd_s, rd_d} <= 3'h0;
		end
		else
		begin
			{wr_m, wr_s, wr_d} <= {wr_tgl_reg, wr_m, wr_s};
			{rd_m, rd_s, rd_d} <= {rd_tgl_reg, rd_m, rd_s};
		end
	end

	wire wr_pulse = wr_s ^ wr_d;
	wire rd_pulse = rd_s ^ rd_d;

	function automatic logic wr_hit(input logic [7:0] a);
		return wr_pulse && (wr_addr_reg == a);
	endfunction : wr_hit

	function automatic logic [31:0] rate_div(input logic [1:0] sel);
		unique case (sel)
			2'h0: return RATE_DIV0;
			2'h1: return RATE_DIV1;
			2'h2: return RATE_DIV2;
			2'h3: return RATE_DIV3;
		endcase
	endfunction : rate_div

	// ==========================================================
	// Core domain: software registers
	logic [7:0] irq_en_reg, cfg1_reg, tmr_cfg_reg, tmr_init_reg, ts_cfg_reg;
	logic       single_go_reg, conv_done;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_en_reg   <= REG_RST;
			cfg1_reg     <= REG_RST;
			tmr_cfg_reg  <= REG_RST;
			tmr_init_reg <= REG_RST;
			ts_cfg_reg   <= REG_RST;
		end
		else
		begin
			if (wr_hit(OFS_IRQ_EN))
				irq_en_reg <= wr_data_reg & IRQ_EN_MASK;
			if (wr_hit(OFS_CFG1))
				cfg1_reg <= wr_data_reg & CFG1_MASK; // RL7 RL8
			if (wr_hit(OFS_TMR_CFG))
				tmr_cfg_reg <= wr_data_reg & TMR_CFG_MASK;
			if (wr_hit(OFS_TMR_INIT))
				tmr_init_reg <= wr_data_reg; // RL14
			if (wr_hit(OFS_TS_CFG))
				ts_cfg_reg <= wr_data_reg & TS_CFG_MASK;
		end
	end

	// A fresh one-shot write wins over the completion that clears the bit.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			single_go_reg <= 1'b0;
		else if (wr_hit(OFS_TS_CFG) && wr_data_reg[BIT_SINGLE] && !wr_data_reg[BIT_AUTO])
			single_go_reg <= 1'b1; // RL2
		else if (conv_done)
			single_go_reg <= 1'b0; // RL3
	end

	wire ret_on = cfg1_reg[BIT_RET];
	wire run    = tmr_cfg_reg[BIT_RUN];
	wire hold   = tmr_cfg_reg[BIT_HOLD];

	assign supply_main_force = ret_on; // RL9
	assign osc_enable        = ~ret_on; // RL7

	a_ret_supply: assert property (@(posedge core_clk) disable iff (!reset_n) // RL9
		$rose(ret_on) |-> supply_main_force && !osc_enable)
		else $error("Retention did not force main supply.");

	// ==========================================================
	// Core domain: base tick, frozen in retention
	logic [31:0] pre_cnt_reg;
	wire         base_tick = !ret_on && (pre_cnt_reg == 32'(BASE_TICK_CYCLES - 1));

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			pre_cnt_reg <= 32'h0;
		else if (ret_on)
			pre_cnt_reg <= pre_cnt_reg; // RL7 RL8
		else if (base_tick)
			pre_cnt_reg <= 32'h0;
		else
			pre_cnt_reg <= pre_cnt_reg + 32'h1;
	end

	// ==========================================================
	// Core domain: countdown timer
	rtcc_tmr_state_t tst_reg;
	logic [7:0]  tmr_cnt_reg;
	logic [31:0] rate_cnt_reg;
	wire counting = (tst_reg == TS_COUNT) && run && !hold;
	wire step     = counting && base_tick &&
		(rate_cnt_reg == rate_div(tmr_cfg_reg[1:0]) - 32'h1); // RL11
	wire tmr_zero = step && (tmr_cnt_reg <= 8'h01);

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			rate_cnt_reg <= 32'h0;
		else if (tst_reg != TS_COUNT)
			rate_cnt_reg <= 32'h0;
		else if (step)
			rate_cnt_reg <= 32'h0;
		else if (counting && base_tick)
			rate_cnt_reg <= rate_cnt_reg + 32'h1;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tst_reg     <= TS_IDLE;
			tmr_cnt_reg <= 8'h00;
		end
		else
		begin
			unique case (tst_reg)
				TS_IDLE:
				begin
					tmr_cnt_reg <= tmr_init_reg; // RL14
					if (run && !hold)
						tst_reg <= TS_COUNT; // RL10
				end
				TS_COUNT:
				begin
					if (!run)
						tst_reg <= TS_IDLE;
					else if (tmr_zero)
					begin
						if (tmr_cfg_reg[BIT_RELOAD])
							tmr_cnt_reg <= tmr_init_reg; // RL12
						else
						begin
							tmr_cnt_reg <= 8'h00;
							tst_reg     <= TS_DONE;
						end
					end
					else if (step)
						tmr_cnt_reg <= tmr_cnt_reg - 8'h01; // RL10 RL15
				end
				TS_DONE:
				begin
					if (!run)
						tst_reg <= TS_IDLE;
				end
			endcase
		end
	end

	a_tmr_idle: assert property (@(posedge core_clk) disable iff (!reset_n) // RL14
		(tst_reg == TS_IDLE) ##1 (tst_reg == TS_IDLE) |-> tmr_cnt_reg == $past(tmr_init_reg))
		else $error("Idle timer not held at initial value.");

	a_tmr_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // RL15
		(tst_reg == TS_COUNT) && run && hold |=> $stable(tmr_cnt_reg))
		else $error("Held timer changed its count.");

	a_ret_freeze: assert property (@(posedge core_clk) disable iff (!reset_n) // RL7
		ret_on && (tst_reg == TS_COUNT) && run |=> $stable(tmr_cnt_reg))
		else $error("Timer moved during retention.");

	a_tmr_reload: assert property (@(posedge core_clk) disable iff (!reset_n) // RL12
		tmr_zero && tmr_cfg_reg[BIT_RELOAD] |=> tmr_cnt_reg == $past(tmr_init_reg)
		&& tst_reg == TS_COUNT)
		else $error("Timer did not reload at zero.");

	// ==========================================================
	// Core domain: temperature conversion
	logic        busy_reg;
	logic [31:0] conv_cnt_reg, ivl_cnt_reg;
	logic [15:0] temp_reg, ratio_reg;
	wire auto_on  = ts_cfg_reg[BIT_AUTO];
	wire [31:0] ivl_lim = IVL_BASE_TICKS << ts_cfg_reg[IVL_LSB +: 3];
	wire auto_due = auto_on && base_tick && (ivl_cnt_reg >= ivl_lim - 32'h1);
	wire launch   = !busy_reg && !ret_on && (auto_due || single_go_reg); // RL1 RL2
	assign conv_done = busy_reg && !ret_on && (conv_cnt_reg == 32'(CONV_CYCLES - 1));

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			ivl_cnt_reg <= 32'h0;
		else if (!auto_on || auto_due)
			ivl_cnt_reg <= 32'h0; // RL1
		else if (base_tick)
			ivl_cnt_reg <= ivl_cnt_reg + 32'h1;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busy_reg     <= 1'b0;
			conv_cnt_reg <= 32'h0;
		end
		else if (launch)
		begin
			busy_reg     <= 1'b1;
			conv_cnt_reg <= 32'h0;
		end
		else if (conv_done)
			busy_reg <= 1'b0; // RL3
		else if (busy_reg && !ret_on)
			conv_cnt_reg <= conv_cnt_reg + 32'h1;
	end

	// The trim word tracks temperature linearly around the nominal ratio.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			temp_reg  <= 16'h0000;
			ratio_reg <= COMP_NOMINAL;
		end
		else if (conv_done)
		begin
			temp_reg  <= temp_sample; // RL4
			ratio_reg <= COMP_NOMINAL - temp_sample; // RL4
		end
	end

	assign frac_div_ratio = ratio_reg;
	assign conv_active    = busy_reg;

	a_single_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // RL3
		conv_done && !wr_pulse |=> !single_go_reg && temp_reg == $past(temp_sample))
		else $error("One-shot bit not cleared at completion.");

	a_single_once: assert property (@(posedge core_clk) disable iff (!reset_n) // RL2
		conv_done && !wr_pulse && !auto_on |=> !busy_reg ##1 !busy_reg)
		else $error("One-shot launched a second conversion.");

	// ==========================================================
	// Core domain: status flags, interrupt pin and read port
	logic [7:0] flags_reg, rd_mux;
	logic       int_n_reg;
	wire        flag_clr = rd_pulse && (rd_addr_reg == OFS_FLAGS);
	wire [7:0]  flag_set = ({7'h00, tmr_zero} << BIT_TIF) | ({7'h00, conv_done} << BIT_TSF);

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			flags_reg <= 8'h00;
		else
			flags_reg <= ((flag_clr ? 8'h00 : flags_reg) | flag_set) & FLAG_MASK; // RL5 RL6 RL13
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			int_n_reg <= 1'b1;
		else
			int_n_reg <= ~|(flags_reg & irq_en_reg & FLAG_MASK); // RL5 RL6 RL13
	end

	assign int_n = int_n_reg;

	always_comb
	begin
		unique case (rd_addr_reg)
			OFS_FLAGS:    rd_mux = flags_reg;
			OFS_IRQ_EN:   rd_mux = irq_en_reg;
			OFS_CFG1:     rd_mux = cfg1_reg;
			OFS_TMR_CFG:  rd_mux = tmr_cfg_reg;
			OFS_TMR_CNT:  rd_mux = tmr_cnt_reg;
			OFS_TMR_INIT: rd_mux = tmr_init_reg;
			OFS_TEMP_HI:  rd_mux = temp_reg[15:8]; // RL4
			OFS_TEMP_LO:  rd_mux = temp_reg[7:0]; // RL4
			OFS_TS_CFG:   rd_mux = ts_cfg_reg | ({7'h00, single_go_reg} << BIT_SINGLE);
			default:      rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_data_reg    <= 8'h00;
			rd_ack_tgl_reg <= 1'b0;
		end
		else if (rd_pulse)
		begin
			rd_data_reg    <= rd_mux;
			rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
		end
	end

	a_int_low: assert property (@(posedge core_clk) disable iff (!reset_n) // RL5
		tmr_zero && irq_en_reg[BIT_TIF] && !flag_clr ##1 irq_en_reg[BIT_TIF] |=> !int_n)
		else $error("Timer event did not pull interrupt low.");

	a_tif_set: assert property (@(posedge core_clk) disable iff (!reset_n) // RL13
		tmr_zero |=> flags_reg[BIT_TIF])
		else $error("Timer flag not set at zero.");

	a_stat_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // RL6
		flag_clr && flag_set == 8'h00 |=> flags_reg == 8'h00 ##1 int_n)
		else $error("Status read did not clear flags and pin.");

endmodule : rtcc_core

// >>> tb/rtcc_bus_host.sv
module rtcc_bus_host
(
	// Bus lines
	output logic      scl,
	output logic      pull,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
	end

	// ==========
	// Bit and byte cycles
	// SDA only moves while SCL is low, so no false START or STOP appears.
	task automatic bit_x(input logic b, output logic r);
		#50 pull = ~b;
		#300 scl = 1'b1;
		#150 r = sda;
		#200 scl = 1'b0;
	endtask : bit_x

	// The wait before releasing lets the device drop its own acknowledge first.
	task automatic start();
		#150 pull = 1'b0;
		#200 scl = 1'b1;
		#200 pull = 1'b1;
		#200 scl = 1'b0;
	endtask : start

	task automatic stop();
		#100 pull = 1'b1;
		#250 scl = 1'b1;
		#250 pull = 1'b0;
		#250;
	endtask : stop

	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask : wr

	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(last, r);
	endtask : rd
endmodule : rtcc_bus_host

// >>> tb/testbench.sv
module testbench
	import rtcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========
	// Clocks, pins and the device
	logic        core_clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [15:0] temp_sample = 16'h0000;
	logic        scl;
	logic        pull;
	logic        sda_out;
	logic        sda_oe;
	logic [15:0] frac_div_ratio;
	logic        osc_enable;
	logic        supply_main_force;
	logic        conv_active;
	logic        int_n;
	wire logic   sda = ~(pull | (sda_oe & ~sda_out));
	int          mismatches = 0;
	int          n_compared = 0;
	int          conv_n = 0;
	logic [31:0] seed = 32'h0000_850E;

	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	// The link clock sits off the whole-nanosecond grid, so bus edges never meet it.
	initial
	begin
		#3.3;
		forever #16 link_clk = ~link_clk;
	end
	always @(posedge conv_active)
		conv_n++;

	// A base tick on every clock keeps the auto-conversion interval short enough to measure.
	rtcc_core #(.CONV_CYCLES(1000), .BASE_TICK_CYCLES(1)) u_dut (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.link_clk(link_clk),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.temp_sample(temp_sample),
		.frac_div_ratio(frac_div_ratio),
		.osc_enable(osc_enable),
		.supply_main_force(supply_main_force),
		.conv_active(conv_active),
		.int_n(int_n)
	);
	rtcc_bus_host u_host (.scl(scl), .pull(pull), .sda(sda));

	// ==========
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [15:0] trim(input logic [15:0] t);
		return COMP_NOMINAL - t;
	endfunction : trim

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic wb(input logic [7:0] d);
		logic k;
		u_host.wr(d, k);
		chk(16'(k), 16'h0001);
	endtask : wb

	task automatic go(input logic [7:0] a, input logic rd);
		u_host.start();
		wb(DEV_WR_BYTE);
		wb(a);
		if (rd)
		begin
			u_host.start();
			wb(DEV_WR_BYTE | 8'h01);
		end
	endtask : go

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		go(a, 1'b0);
		wb(d);
		u_host.stop();
	endtask : wreg

	task automatic rreg(input logic [7:0] a, output logic [7:0] v);
		go(a, 1'b1);
		u_host.rd(1'b1, v);
		u_host.stop();
	endtask : rreg

	task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
		n = 0;
		while (s !== v && n < lim)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask : wait_for

	initial
	begin
		#1_100_000;
		mismatches++;
		end_sim();
	end

	// ==========
	// Scenarios
	initial
	begin
		logic [7:0] r1, r3, v, c1, c2, c3;
		logic [7:0] bad [2] = '{8'hD2, 8'h50};
		logic [15:0] t;
		logic k;
		int n, m;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk({int_n, osc_enable, supply_main_force, conv_active, sda_oe, 11'h0}, 16'hC000);
		chk(frac_div_ratio, COMP_NOMINAL);
		seed = lfsr(seed);
		r1 = seed[7:0];
		r3 = {4'h0, seed[11:8]};
		go(OFS_IRQ_EN, 1'b0);
		wb(r1);
		wb(8'hFF);
		wb(r3);
		u_host.stop();
		go(OFS_IRQ_EN, 1'b1);
		u_host.rd(1'b0, v);
		chk(16'(v), 16'(r1 & IRQ_EN_MASK));
		u_host.rd(1'b0, v);
		chk(16'(v), 16'h0000);
		u_host.rd(1'b1, v);
		chk(16'(v), 16'(r3));
		u_host.stop();
		foreach (bad[i])
		begin
			u_host.start();
			u_host.wr(bad[i], k);
			chk(16'(k), 16'h0000);
			u_host.wr(OFS_IRQ_EN, k);
			chk(16'(k), 16'h0000);
			u_host.wr(8'h00, k);
			u_host.stop();
		end
		rreg(OFS_IRQ_EN, v);
		chk(16'(v), 16'(r1 & IRQ_EN_MASK));
		wreg(OFS_IRQ_EN, 8'h04);
		wreg(OFS_TMR_INIT, 8'h08);
		wreg(OFS_TMR_CFG, 8'h11);
		wait_for(int_n, 1'b0, 2000, n);
		chk(16'(n >= 50 && n <= 600), 16'h0001);
		chk(16'(int_n), 16'h0000);
		rreg(OFS_FLAGS, v);
		chk(16'(v), 16'h0004);
		chk(16'(int_n), 16'h0001);
		rreg(OFS_FLAGS, v);
		chk(16'(v), 16'h0000);
		wreg(OFS_TMR_CFG, 8'h00);
		wreg(OFS_IRQ_EN, 8'h00);
		wreg(OFS_TMR_CFG, 8'h14);
		repeat (2)
		begin
			rreg(OFS_FLAGS, v);
			chk(16'(v), 16'h0004);
			chk(16'(int_n), 16'h0001);
		end
		wreg(OFS_TMR_CFG, 8'h00);
		wreg(OFS_TMR_INIT, 8'hC8);
		wreg(OFS_TMR_CFG, 8'h11);
		rreg(OFS_TMR_CNT, c1);
		wreg(OFS_TMR_CFG, 8'h19);
		rreg(OFS_TMR_CNT, c2);
		rreg(OFS_TMR_CNT, c3);
		chk(16'(c3), 16'(c2));
		chk(16'(c2 < c1 && c1 < 8'hC8), 16'h0001);
		wreg(OFS_TMR_CFG, 8'h11);
		wreg(OFS_CFG1, 8'h10);
		chk({14'h0, osc_enable, supply_main_force}, 16'h0001);
		rreg(OFS_TMR_CNT, c1);
		rreg(OFS_TMR_CNT, c3);
		chk(16'(c3), 16'(c1));
		chk(16'(c1 < c2 && c1 + 8'h28 > c2), 16'h0001);
		wreg(OFS_CFG1, 8'h00);
		chk({14'h0, osc_enable, supply_main_force}, 16'h0002);
		rreg(OFS_TMR_CNT, c3);
		chk(16'(c3 < c1), 16'h0001);
		wreg(OFS_TMR_CFG, 8'h00);
		go(OFS_TMR_INIT, 1'b0);
		u_host.stop();
		u_host.start();
		wb(DEV_WR_BYTE | 8'h01);
		u_host.rd(1'b1, v);
		u_host.stop();
		chk(16'(v), 16'h00C8);
		seed = lfsr(seed);
		t = seed[15:0];
		@(posedge core_clk);
		temp_sample <= t;
		wreg(OFS_TS_CFG, 8'h40);
		chk(16'(conv_active), 16'h0001);
		wait_for(conv_active, 1'b0, 3000, n);
		chk(frac_div_ratio, trim(t));
		rreg(OFS_TEMP_HI, v);
		chk(16'(v), 16'(t[15:8]));
		rreg(OFS_TEMP_LO, v);
		chk(16'(v), 16'(t[7:0]));
		rreg(OFS_TS_CFG, v);
		chk(16'(v), 16'h0000);
		rreg(OFS_FLAGS, v);
		// The timer flag left behind by the reload run is still pending here.
		chk(16'(v), 16'h000C);
		chk(16'(conv_n), 16'h0001);
		wreg(OFS_TS_CFG, 8'h80);
		wait_for(conv_active, 1'b1, 17000, n);
		wait_for(conv_active, 1'b0, 3000, n);
		wait_for(conv_active, 1'b1, 17000, m);
		chk(16'(n + m), 16'h1000);
		wreg(OFS_TS_CFG, 8'h00);
		end_sim();
	end
endmodule : testbench
